//--- verilog/hmb_pkg.sv
`default_nettype none
package hmb_pkg;
  localparam int unsigned AXI_AW = 6;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned RAM_AW = 14;
  localparam int unsigned RAM_DW = 8;
  localparam int unsigned RAM_BYTES = 16384;
  localparam int unsigned N_FLAGS = 3;
  localparam int unsigned RD_LATENCY = 2;

  localparam logic [AXI_AW-1:0] OFS_CAUSE = 6'h00;
  localparam logic [AXI_AW-1:0] OFS_MASK = 6'h04;
  localparam logic [AXI_AW-1:0] OFS_FORCE = 6'h08;
  localparam logic [AXI_AW-1:0] OFS_PTR_LO = 6'h0C;
  localparam logic [AXI_AW-1:0] OFS_PTR_HI = 6'h10;
  localparam logic [AXI_AW-1:0] OFS_AUTOINC = 6'h14;
  localparam logic [AXI_AW-1:0] OFS_STAY = 6'h18;
  localparam logic [AXI_AW-1:0] OFS_HCMD = 6'h1C;
  localparam logic [AXI_AW-1:0] OFS_DMSG = 6'h20;

  localparam int unsigned BIT_CMD = 0;
  localparam int unsigned BIT_LINK = 1;
  localparam int unsigned BIT_MSG = 2;
  localparam logic [N_FLAGS-1:0] FORCE_OK = 3'h5;
  localparam logic [N_FLAGS-1:0] FLAGS_RST = 3'h0;
  localparam logic [N_FLAGS-1:0] MASK_RST = 3'h0;
  localparam logic [RAM_AW-1:0] PTR_RST = 14'h0000;
  localparam logic [RAM_AW-1:0] PTR_ONE = 14'h0001;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    HMB_RD_IDLE = 3'b001,
    HMB_RD_RAM = 3'b010,
    HMB_RD_RESP = 3'b100
  } hmb_rd_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic [AXI_AW-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wlane;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [AXI_AW-1:0] raddr;
    hmb_rd_t rd;
    logic [RAM_AW-1:0] ptr;
    logic [N_FLAGS-1:0] mask;
    logic [7:0] host_cmd;
    logic cmd_new;
    logic [7:0] dev_msg;
    logic irq;
  } hmb_state_t;

  localparam hmb_state_t STATE_RST = '{
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    rd: HMB_RD_IDLE,
    ptr: PTR_RST,
    mask: MASK_RST,
    host_cmd: CMD_RST,
    dev_msg: CMD_RST,
    default: '0
  };
endpackage
`default_nettype wire

//--- verilog/hmb_flag.sv
`timescale 1ns/1ns
`default_nettype none
module hmb_flag (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  import hmb_pkg::*;

  typedef struct packed {
    logic flag;
  } hmb_flag_t;

  hmb_flag_t q;
  hmb_flag_t d;

  always_comb begin
    d = q;
    // an event in the clearing cycle must not be lost
    if (set_in) begin
      d.flag = 1'b1;
    end else if (clr_in) begin
      d.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flag_out = q.flag;

  a_set_wins: assert property (@(posedge core_clk_in) disable iff (rst_in) set_in |=> flag_out)
    else $error("flag lost an event");
endmodule
`default_nettype wire

//--- verilog/hmb_ram.sv
`timescale 1ns/1ns
`default_nettype none
module hmb_ram #(
  parameter int unsigned AW = hmb_pkg::RAM_AW,
  parameter int unsigned DW = hmb_pkg::RAM_DW
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic a_we_in,
  input wire logic [AW-1:0] a_addr_in,
  input wire logic [DW-1:0] a_wdata_in,
  output logic [DW-1:0] a_rdata_out,
  input wire logic b_we_in,
  input wire logic [AW-1:0] b_addr_in,
  input wire logic [DW-1:0] b_wdata_in,
  output logic [DW-1:0] b_rdata_out
);
  import hmb_pkg::*;

  // contents are not reset; only the read registers are
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk_in) begin
    if (a_we_in) begin
      mem[a_addr_in] <= a_wdata_in;
    end
    if (b_we_in) begin
      mem[b_addr_in] <= b_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      a_rdata_out <= '0;
      b_rdata_out <= '0;
    end else begin
      a_rdata_out <= mem[a_addr_in];
      b_rdata_out <= mem[b_addr_in];
    end
  end
endmodule
`default_nettype wire

//--- verilog/hmb_top.sv
`timescale 1ns/1ns
`default_nettype none
module hmb_top (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [hmb_pkg::AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [hmb_pkg::AXI_DW-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [hmb_pkg::AXI_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [hmb_pkg::AXI_DW-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic eng_cmd_taken_in,
  input wire logic link_reset_in,
  input wire logic eng_msg_we_in,
  input wire logic [7:0] eng_msg_data_in,
  output logic [7:0] host_cmd_out,
  output logic host_cmd_new_out,
  output logic irq_out,
  input wire logic eng_ram_we_in,
  input wire logic [hmb_pkg::RAM_AW-1:0] eng_ram_addr_in,
  input wire logic [hmb_pkg::RAM_DW-1:0] eng_ram_wdata_in,
  output logic [hmb_pkg::RAM_DW-1:0] eng_ram_rdata_out
);
  import hmb_pkg::*;

  hmb_state_t q;
  hmb_state_t d;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic ram_we;
  logic cmd_wr;
  logic [RAM_DW-1:0] ram_rdata;
  logic [RAM_AW-1:0] ptr_inc;
  logic [N_FLAGS-1:0] flags;
  logic [N_FLAGS-1:0] cause_clr;
  logic [N_FLAGS-1:0] force_set;
  logic [N_FLAGS-1:0] set_vec;
  logic [N_FLAGS-1:0] clr_vec;

  function automatic logic [AXI_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
    word_of = {a[AXI_AW-1:2], 2'b00};
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = word_of(a);
    mapped = (w == OFS_CAUSE) || (w == OFS_MASK) || (w == OFS_FORCE) ||
             (w == OFS_PTR_LO) || (w == OFS_PTR_HI) || (w == OFS_AUTOINC) ||
             (w == OFS_STAY) || (w == OFS_HCMD) || (w == OFS_DMSG);
  endfunction

  assign aw_hs = s_axi_awvalid_in && q.awready;
  assign w_hs = s_axi_wvalid_in && q.wready;
  assign ar_hs = s_axi_arvalid_in && q.arready;
  // a read fetch owns the memory port and the pointer in its handshake cycle
  assign wr_go = q.aw_have && q.w_have && !ar_hs;
  assign ptr_inc = q.ptr + PTR_ONE;

  always_comb begin
    d = q;
    cause_clr = '0;
    force_set = '0;
    ram_we = 1'b0;
    cmd_wr = 1'b0;
    d.cmd_new = 1'b0;

    if (aw_hs) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr_in;
      d.awready = 1'b0;
    end
    if (w_hs) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata_in[7:0];
      d.wlane = s_axi_wstrb_in[0];
      d.wready = 1'b0;
    end

    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      // lane 0 carries every register; without it the write is a no-op
      if (q.wlane) begin
        case (word_of(q.awaddr))
          OFS_CAUSE: begin
            cause_clr = q.wdata[N_FLAGS-1:0];
          end
          OFS_MASK: begin
            d.mask = q.wdata[N_FLAGS-1:0];
          end
          OFS_FORCE: begin
            // bit1 is reserved: a bus reset cannot be faked by software
            force_set = q.wdata[N_FLAGS-1:0] & FORCE_OK;
          end
          OFS_PTR_LO: begin
            d.ptr[7:0] = q.wdata;
          end
          OFS_PTR_HI: begin
            d.ptr[RAM_AW-1:8] = q.wdata[RAM_AW-9:0];
          end
          OFS_AUTOINC: begin
            ram_we = 1'b1;
            d.ptr = ptr_inc;
          end
          OFS_STAY: begin
            ram_we = 1'b1;
          end
          OFS_HCMD: begin
            d.host_cmd = q.wdata;
            d.cmd_new = 1'b1;
            cmd_wr = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    unique case (q.rd)
      HMB_RD_IDLE: begin
        if (ar_hs) begin
          d.raddr = s_axi_araddr_in;
          d.arready = 1'b0;
          d.rd = HMB_RD_RAM;
          if (word_of(s_axi_araddr_in) == OFS_AUTOINC) begin
            d.ptr = ptr_inc;
          end
        end
      end
      HMB_RD_RAM: begin
        d.rvalid = 1'b1;
        d.rd = HMB_RD_RESP;
        d.rresp = mapped(q.raddr) ? RESP_OKAY : RESP_SLVERR;
        case (word_of(q.raddr))
          OFS_CAUSE: d.rdata = 8'(flags);
          OFS_MASK: d.rdata = 8'(q.mask);
          OFS_PTR_LO: d.rdata = q.ptr[7:0];
          OFS_PTR_HI: d.rdata = 8'(q.ptr[RAM_AW-1:8]);
          OFS_AUTOINC: d.rdata = ram_rdata;
          OFS_STAY: d.rdata = ram_rdata;
          OFS_HCMD: d.rdata = q.host_cmd;
          OFS_DMSG: d.rdata = q.dev_msg;
          default: d.rdata = 8'h00;
        endcase
      end
      HMB_RD_RESP: begin
        if (s_axi_rready_in) begin
          d.rvalid = 1'b0;
          d.arready = 1'b1;
          d.rd = HMB_RD_IDLE;
        end
      end
    endcase

    if (eng_msg_we_in) begin
      d.dev_msg = eng_msg_data_in;
    end
    // registered so the pin cannot glitch while flags settle
    d.irq = |(flags & q.mask);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign set_vec[BIT_CMD] = eng_cmd_taken_in || force_set[BIT_CMD];
  assign set_vec[BIT_LINK] = link_reset_in || force_set[BIT_LINK];
  assign set_vec[BIT_MSG] = eng_msg_we_in || force_set[BIT_MSG];
  assign clr_vec = cause_clr | (cmd_wr ? N_FLAGS'(1 << BIT_CMD) : '0);

  generate
    for (genvar i = 0; i < N_FLAGS; i++) begin : g_flag
      hmb_flag u_flag (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .set_in(set_vec[i]),
        .clr_in(clr_vec[i]),
        .flag_out(flags[i])
      );
    end
  endgenerate

  // host port and engine port of one shared array
  hmb_ram #(
    .AW(RAM_AW),
    .DW(RAM_DW)
  ) u_ram (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .a_we_in(ram_we),
    .a_addr_in(q.ptr),
    .a_wdata_in(q.wdata),
    .a_rdata_out(ram_rdata),
    .b_we_in(eng_ram_we_in),
    .b_addr_in(eng_ram_addr_in),
    .b_wdata_in(eng_ram_wdata_in),
    .b_rdata_out(eng_ram_rdata_out)
  );

  assign s_axi_awready_out = q.awready;
  assign s_axi_wready_out = q.wready;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_arready_out = q.arready;
  assign s_axi_rdata_out = {24'h00_0000, q.rdata};
  assign s_axi_rresp_out = q.rresp;
  assign s_axi_rvalid_out = q.rvalid;
  assign host_cmd_out = q.host_cmd;
  assign host_cmd_new_out = q.cmd_new;
  assign irq_out = q.irq;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  logic wr_auto;
  logic wr_cause;
  logic rd_auto;
  logic rd_stay;
  logic rd_ctl;
  assign wr_auto = wr_go && q.wlane && (word_of(q.awaddr) == OFS_AUTOINC);
  assign wr_cause = wr_go && q.wlane && (word_of(q.awaddr) == OFS_CAUSE);
  assign rd_auto = ar_hs && (word_of(s_axi_araddr_in) == OFS_AUTOINC);
  assign rd_stay = ar_hs && (word_of(s_axi_araddr_in) == OFS_STAY);
  assign rd_ctl = (word_of(q.raddr) == OFS_CAUSE) || (word_of(q.raddr) == OFS_MASK) ||
                  (word_of(q.raddr) == OFS_FORCE);

  a_cmd_flag_set: assert property (eng_cmd_taken_in |=> flags[BIT_CMD])
    else $error("command-taken flag not set");
  a_link_flag_set: assert property (link_reset_in |=> flags[BIT_LINK])
    else $error("link reset flag not set");
  a_msg_flag_set: assert property (eng_msg_we_in |=> flags[BIT_MSG] && q.dev_msg == $past(eng_msg_data_in))
    else $error("outbound message not posted");
  a_rsvd_read_zero: assert property (q.rvalid && rd_ctl |-> q.rdata[7:N_FLAGS] == '0)
    else $error("reserved bits read nonzero");
  a_auto_rd_ptr: assert property (rd_auto |=> q.ptr == $past(ptr_inc))
    else $error("auto read did not advance pointer");
  a_auto_wr_ptr: assert property (wr_auto |=> q.ptr == $past(ptr_inc))
    else $error("auto write did not advance pointer");
  a_stay_rd_ptr: assert property (rd_stay |=> $stable(q.ptr))
    else $error("fixed port read moved pointer");
  a_cause_clear: assert property (wr_cause && q.wdata[BIT_LINK] && !link_reset_in |=> !flags[BIT_LINK])
    else $error("cause write did not clear flag");
  a_irq_follows: assert property ((|(flags & q.mask)) |=> irq_out ##1 1'b1)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (!(|(flags & q.mask)) |=> !irq_out)
    else $error("interrupt raised without cause");
  a_hcmd_clears: assert property (cmd_wr && !eng_cmd_taken_in && !force_set[BIT_CMD] |=> !flags[BIT_CMD])
    else $error("command write kept flag");
  a_rd_latency: assert property (ar_hs |-> !q.rvalid ##2 q.rvalid)
    else $error("read answer late");
  a_b_hold: assert property (q.bvalid && !s_axi_bready_in |=> q.bvalid && $stable(q.bresp))
    else $error("write response dropped");

  // decodes of the executing write, for the checks below only
  logic wr_force;
  logic wr_stay;
  logic wr_ptr_lo;
  assign wr_force = wr_go && q.wlane && (word_of(q.awaddr) == OFS_FORCE);
  assign wr_stay = wr_go && q.wlane && (word_of(q.awaddr) == OFS_STAY);
  assign wr_ptr_lo = wr_go && q.wlane && (word_of(q.awaddr) == OFS_PTR_LO);

  a_force_sets: assert property (wr_force && q.wdata[BIT_CMD] |=> flags[BIT_CMD])
    else $error("force did not set flag");
  // the link flag may only come from the link, never from software
  a_force_link_rsvd: assert property (wr_force && !link_reset_in && !flags[BIT_LINK] |=> !flags[BIT_LINK])
    else $error("reserved force bit acted");
  a_zero_keeps: assert property (wr_cause && !q.wdata[BIT_MSG] && flags[BIT_MSG] |=> flags[BIT_MSG])
    else $error("zero write cleared flag");
  a_stay_wr_ptr: assert property (wr_stay |=> $stable(q.ptr))
    else $error("fixed port write moved pointer");
  a_ptr_wrap: assert property (wr_auto && (&q.ptr) |=> q.ptr == PTR_RST)
    else $error("pointer did not wrap");
  a_ptr_lo_write: assert property (wr_ptr_lo |=> q.ptr[7:0] == $past(q.wdata))
    else $error("pointer low byte not written");
  a_strb_ignored: assert property (wr_go && !q.wlane |=> $stable(q.ptr) && $stable(q.mask))
    else $error("write without lane 0 acted");
  a_b_after_go: assert property (wr_go |=> q.bvalid)
    else $error("write response missing");
  a_aw_blocked: assert property (aw_hs |=> !s_axi_awready_out)
    else $error("second write address accepted");
  a_ar_blocked: assert property (ar_hs |=> !s_axi_arready_out)
    else $error("second read address accepted");
  a_cmd_pulse: assert property (cmd_wr |=> host_cmd_new_out && host_cmd_out == $past(q.wdata))
    else $error("host command not presented");
  a_dmsg_hold: assert property (!eng_msg_we_in |=> $stable(q.dev_msg))
    else $error("device message changed by host");
  a_unmapped_rd: assert property (q.rvalid && !mapped(q.raddr) |-> q.rresp == RESP_SLVERR && q.rdata == 8'h00)
    else $error("unmapped read not refused");

  c_auto_read: cover property (rd_auto ##2 q.rvalid);
  c_cause_clear: cover property (wr_cause && |flags);
  c_irq_rise: cover property ($rose(irq_out));
  c_ptr_wrap: cover property (wr_auto && q.ptr == '1);
  c_link_seen: cover property ($rose(flags[BIT_LINK]));
endmodule
`default_nettype wire

//--- tb/hmb_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module hmb_engine_model #(
  parameter int unsigned TAKE_DELAY = 20
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic host_cmd_new_in,
  input wire logic link_evt_in,
  input wire logic msg_evt_in,
  input wire logic [7:0] msg_byte_in,
  input wire logic [13:0] peek_addr_in,
  output logic eng_cmd_taken_out,
  output logic link_reset_out,
  output logic eng_msg_we_out,
  output logic [7:0] eng_msg_data_out,
  output logic eng_ram_we_out,
  output logic [13:0] eng_ram_addr_out,
  output logic [7:0] eng_ram_wdata_out
);
  logic [7:0] cnt_q;
  // engine consumes the command byte some time after it arrives
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_q <= 8'h00;
    end else if (host_cmd_new_in) begin
      cnt_q <= TAKE_DELAY[7:0];
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign eng_cmd_taken_out = (cnt_q == 8'h01);
  assign link_reset_out = link_evt_in;
  assign eng_msg_we_out = msg_evt_in;
  // data not valid outside a write: show the inverse, never a stale copy
  assign eng_msg_data_out = msg_evt_in ? msg_byte_in : ~msg_byte_in;
  // engine only peeks at the shared memory here
  assign eng_ram_we_out = 1'b0;
  assign eng_ram_addr_out = peek_addr_in;
  assign eng_ram_wdata_out = 8'h00;
endmodule
`default_nettype wire

//--- tb/host_mailbox_ram_access_test.sv
`timescale 1ns/1ns
`default_nettype none
module host_mailbox_ram_access_test;
  import hmb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic link_evt = 1'b0, msg_evt = 1'b0;
  logic [7:0] msg_byte = 8'h00;
  logic [13:0] peek_addr = 14'h0000;
  logic awready, wready, bvalid, arready, rvalid, host_cmd_new, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] host_cmd, ram_rdata, msg_data, ram_wdata;
  logic cmd_taken, link_rst, msg_we, ram_we;
  logic [13:0] ram_addr;
  int fail_count = 0;
  int n_compared = 0;

  always #20 clk = ~clk;

  hmb_top i_dut (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .eng_cmd_taken_in(cmd_taken), .link_reset_in(link_rst), .eng_msg_we_in(msg_we),
    .eng_msg_data_in(msg_data), .host_cmd_out(host_cmd), .host_cmd_new_out(host_cmd_new), .irq_out(irq),
    .eng_ram_we_in(ram_we), .eng_ram_addr_in(ram_addr), .eng_ram_wdata_in(ram_wdata),
    .eng_ram_rdata_out(ram_rdata));

  hmb_engine_model #(.TAKE_DELAY(20)) i_eng (.core_clk_in(clk), .rst_in(rst), .host_cmd_new_in(host_cmd_new),
    .link_evt_in(link_evt), .msg_evt_in(msg_evt), .msg_byte_in(msg_byte), .peek_addr_in(peek_addr),
    .eng_cmd_taken_out(cmd_taken), .link_reset_out(link_rst), .eng_msg_we_out(msg_we),
    .eng_msg_data_out(msg_data), .eng_ram_we_out(ram_we), .eng_ram_addr_out(ram_addr),
    .eng_ram_wdata_out(ram_wdata));

  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    logic aw;
    logic w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (!aw && !w && bvalid) begin
        chk_val({30'h0000_0000, bresp}, {30'h0000_0000, er});
        break;
      end
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    if (n >= 100) begin
      chk_bit(1'b0, 1'b1);
    end
  endtask

  task automatic axi_rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ar;
    int n;
    ar = 1'b1;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (!ar && rvalid) begin
        chk_val(rdata, {24'h00_0000, d});
        chk_val({30'h0000_0000, rresp}, {30'h0000_0000, er});
        break;
      end
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end
    if (n >= 100) begin
      chk_bit(1'b0, 1'b1);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    axi_wr(a, d, 4'h1, RESP_OKAY);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] d);
    axi_rd(a, d, RESP_OKAY);
  endtask

  task automatic set_ptr(input logic [13:0] p);
    wr(OFS_PTR_LO, p[7:0]);
    wr(OFS_PTR_HI, {2'b00, p[13:8]});
  endtask

  task automatic pulse(input logic is_msg);
    if (is_msg) msg_evt <= 1'b1;
    else link_evt <= 1'b1;
    @(posedge clk);
    msg_evt <= 1'b0;
    link_evt <= 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_bit(irq, 1'b0);
    rd(OFS_CAUSE, 8'h00);
    rd(OFS_MASK, 8'h00);
    rd(OFS_PTR_LO, 8'h00);
    wr(OFS_PTR_LO, 8'ha5);
    wr(OFS_PTR_HI, 8'hff);
    rd(OFS_PTR_LO, 8'ha5);
    rd(OFS_PTR_HI, 8'h3f);
    // load an image, then read it back through the stepping port
    set_ptr(14'h0010);
    for (int i = 0; i < 4; i++) wr(OFS_AUTOINC, 8'h30 + 8'(i));
    set_ptr(14'h0010);
    for (int i = 0; i < 4; i++) rd(OFS_AUTOINC, 8'h30 + 8'(i));
    rd(OFS_PTR_LO, 8'h14);
    set_ptr(14'h3ffe);
    wr(OFS_AUTOINC, 8'h11);
    wr(OFS_AUTOINC, 8'h22);
    rd(OFS_PTR_LO, 8'h00);
    rd(OFS_PTR_HI, 8'h00);
    set_ptr(14'h3fff);
    wr(OFS_STAY, 8'h5a);
    axi_wr(OFS_STAY, 8'h77, 4'h0, RESP_OKAY);
    rd(OFS_STAY, 8'h5a);
    rd(OFS_PTR_LO, 8'hff);
    rd(OFS_AUTOINC, 8'h5a);
    rd(OFS_PTR_HI, 8'h00);
    peek_addr <= 14'h3ffe;
    repeat (3) @(posedge clk);
    chk_val({24'h00_0000, ram_rdata}, 32'h0000_0011);
    wr(OFS_FORCE, 8'hff);
    rd(OFS_CAUSE, 8'h05);
    rd(OFS_FORCE, 8'h00);
    chk_bit(irq, 1'b0);
    wr(OFS_MASK, 8'hff);
    rd(OFS_MASK, 8'h07);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b1);
    wr(OFS_CAUSE, 8'h00);
    rd(OFS_CAUSE, 8'h05);
    wr(OFS_CAUSE, 8'h05);
    rd(OFS_CAUSE, 8'h00);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
    pulse(1'b0);
    rd(OFS_CAUSE, 8'h02);
    wr(OFS_CAUSE, 8'h02);
    wr(OFS_MASK, 8'h01);
    msg_byte <= 8'h9e;
    pulse(1'b1);
    rd(OFS_CAUSE, 8'h04);
    chk_bit(irq, 1'b0);
    rd(OFS_DMSG, 8'h9e);
    wr(OFS_DMSG, 8'h00);
    rd(OFS_DMSG, 8'h9e);
    wr(OFS_CAUSE, 8'h04);
    wr(OFS_HCMD, 8'h3c);
    chk_bit(host_cmd_new, 1'b1);
    chk_val({24'h00_0000, host_cmd}, 32'h0000_003c);
    rd(OFS_CAUSE, 8'h00);
    repeat (25) @(posedge clk);
    rd(OFS_CAUSE, 8'h01);
    chk_bit(irq, 1'b1);
    wr(OFS_HCMD, 8'hc3);
    rd(OFS_CAUSE, 8'h00);
    rd(OFS_HCMD, 8'hc3);
    axi_wr(6'h24, 8'h12, 4'h1, RESP_SLVERR);
    axi_rd(6'h24, 8'h00, RESP_SLVERR);
    give_verdict();
  end
endmodule
`default_nettype wire
